// [hdl/asc_ctrl.sv]
/*
  host side controller for a 32K x 8 asynchronous static memory: takes
  single read or write requests and sequences select, write strobe,
  output enable, address and the three-signal data bus.
  assumes: memory pins driven directly, wire resolved outside from the
  enable, one 10 MHz clock, requests from logic in the same domain.
*/
`timescale 1ns/100ps
module asc_ctrl
  import asc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic      [DATA_W-1:0] rsp_rdata,
  output logic      [ADDR_W-1:0] mem_addr,
  output logic                   mem_sel_n,
  output logic                   mem_wr_n,
  output logic                   mem_oe_n,
  input  wire logic [DATA_W-1:0] mem_data_i,
  output logic      [DATA_W-1:0] mem_data_o,
  output logic                   mem_data_oe_n
);
  asc_state_e       state_q;   // sequence state
  logic [CNT_W-1:0] cnt_q;     // cycle timer within a phase
  logic [DATA_W-1:0] rd_sync;  // synchronised data pins

  // cycle walk of a read, counted from the edge that takes it:
  //   edge 0: address set, select and output enable fall
  //   edges 1 to 3: access time plus two synchroniser stages
  //   edge 4: select and output enable rise together
  //   edge 5: synchronised byte captured, answer pulse raised
  //   edge 6 and 7: memory drivers given time to float
  //   edge 7: ready raised again, back in idle
  // cycle walk of a write, counted from the edge that takes it:
  //   edge 0: address and write byte registered, select still high
  //   edge 1: select, strobe and data drive fall together
  //   edge 2: select and strobe rise, data still driven for hold
  //   edge 3: data released, ready raised again
  // hazards kept in mind:
  //   the address only moves in idle, where select and strobe are high,
  //   so no write can straddle an address change
  //   select falls with the strobe in a write and output enable stays
  //   high, so the memory never turns its drivers on during a write
  //   the data drive outlasts the strobe by one cycle so the byte is
  //   still on the pins when the strobe ends
  //   after a read the bus is left alone until the float wait is over
  // limitation: one 100 ns cycle is far longer than any minimum here, so
  // every phase is a whole number of cycles and no phase is shortened

  // read data pins pass two flops before use
  asc_sync #(.W(DATA_W)) u_sync (
    .clk  (clk),
    .rst_n(rst_n),
    .din  (mem_data_i),
    .dout (rd_sync)
  );

  // sequence state and phase timer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ASC_IDLE;
      cnt_q   <= CNT_RST;
    end else begin
      case (state_q)
        // wait for a request, timer held at zero
        ASC_IDLE: begin
          cnt_q <= CNT_RST;
          // writes take priority in decoding, only one at a time anyway
          if (req_valid && req_write) begin
            state_q <= ASC_WR_SETUP;
          end else if (req_valid) begin
            state_q <= ASC_RD_WAIT;
          end
        end
        // wait access plus two synchroniser stages
        ASC_RD_WAIT: begin
          if (cnt_q >= CNT_W'(ACC_CYC + 2)) begin
            state_q <= ASC_RD_DONE;
            cnt_q   <= CNT_RST;
          end else begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        // deselect, then let the memory float the bus
        ASC_RD_DONE: begin
          state_q <= ASC_FLOAT;
        end
        // select and enable are high, memory drivers turning off
        ASC_FLOAT: begin
          // the longer of the two float figures, rounded up to cycles
          if (cnt_q >= CNT_W'(FLOAT_CYC)) begin
            state_q <= ASC_IDLE;
          end else begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        // address settles while deselected
        ASC_WR_SETUP: begin
          state_q <= ASC_WR_PULSE;
        end
        // hold the pulse for the longer oe-low figure
        ASC_WR_PULSE: begin
          if (cnt_q >= CNT_W'(WP_CYC - 1)) begin
            state_q <= ASC_WR_REC;
            cnt_q   <= CNT_RST;
          end else begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        // recovery counted from strobe release
        ASC_WR_REC: begin
          state_q <= ASC_IDLE;
        end
        // unused encoding: recover to idle with the timer cleared
        default: begin
          state_q <= ASC_IDLE;
          cnt_q   <= CNT_RST;
        end
      endcase
    end
  end

  // address latched only while select is high
  // the request is taken in idle, so the pin moves with select high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_addr <= '0;
    end else if (state_q == ASC_IDLE && req_valid) begin
      mem_addr <= req_addr;
    end
  end

  // select low for read wait and for the write pulse only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_sel_n <= 1'b1;
    end else begin
      case (state_q)
        ASC_IDLE:     mem_sel_n <= !(req_valid && !req_write);
        ASC_RD_WAIT:  mem_sel_n <= (cnt_q >= CNT_W'(ACC_CYC + 2));
        // select falls with the strobe so the memory never drives
        ASC_WR_SETUP: mem_sel_n <= 1'b0;
        ASC_WR_PULSE: mem_sel_n <= (cnt_q >= CNT_W'(WP_CYC - 1));
        default:      mem_sel_n <= 1'b1;
      endcase
    end
  end

  // write strobe low only in the pulse, high in reads
  // strobe and select share one timing, so both bound the write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_wr_n <= 1'b1;
    end else begin
      case (state_q)
        ASC_WR_SETUP: mem_wr_n <= 1'b0;
        ASC_WR_PULSE: mem_wr_n <= (cnt_q >= CNT_W'(WP_CYC - 1));
        default:      mem_wr_n <= 1'b1;
      endcase
    end
  end

  // output enable low only during read; high in writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_oe_n <= 1'b1;
    end else begin
      case (state_q)
        ASC_IDLE:    mem_oe_n <= !(req_valid && !req_write);
        ASC_RD_WAIT: mem_oe_n <= (cnt_q >= CNT_W'(ACC_CYC + 2));
        default:     mem_oe_n <= 1'b1;
      endcase
    end
  end

  // drive data only in write pulse and recovery, never after a read
  // until the float wait is over
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_data_o    <= '0;
      mem_data_oe_n <= 1'b1;
    end else begin
      if (state_q == ASC_IDLE && req_valid && req_write) begin
        mem_data_o <= req_wdata;
      end
      case (state_q)
        ASC_WR_SETUP: mem_data_oe_n <= 1'b0;
        ASC_WR_PULSE: mem_data_oe_n <= 1'b0;
        default:      mem_data_oe_n <= 1'b1;
      endcase
    end
  end

  // request handshake and read answer
  // ready is registered but decoded from the last cycle before idle, so it rises as idle is entered; a request
  // seen in idle drops it at once so a second one is not taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      req_ready <= (state_q == ASC_FLOAT && cnt_q >= CNT_W'(FLOAT_CYC))
                || state_q == ASC_WR_REC
                || (state_q == ASC_IDLE && !req_valid);
      rsp_valid <= (state_q == ASC_RD_DONE);
      if (state_q == ASC_RD_DONE) begin
        rsp_rdata <= rd_sync;
      end
    end
  end
endmodule : asc_ctrl

// [hdl/asc_pkg.sv]
/*
  constants for the static memory access controller: pin widths, timing
  figures in ns, cycle counts derived from the 10 MHz clock, states.
  assumes: the controller runs on a single 100 ns clock.
*/
package asc_pkg;
  localparam int CLK_PERIOD_NS  = 100;  // clock period in ns
  localparam int ADDR_W         = 15;   // address width
  localparam int DATA_W         = 8;    // data width
  localparam int WRITE_PULSE_NS = 9;    // minimum write pulse
  localparam int WHZ_NS         = 8;    // strobe to float
  localparam int DATA_OVERLAP_NS = 6;   // data_overlap_time
  localparam int ACCESS_NS      = 10;   // read access time
  localparam int OHZ_NS         = 6;    // enable to float
  localparam int CHZ_NS         = 8;    // select to float
  // longest of the write pulse options
  localparam int WP_OE_LOW_NS   = (WHZ_NS + DATA_OVERLAP_NS > WRITE_PULSE_NS)
                                  ? WHZ_NS + DATA_OVERLAP_NS : WRITE_PULSE_NS;
  // least times round up, at least one cycle
  localparam int WP_CYC    = (WP_OE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACC_CYC   = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLOAT_NS  = (OHZ_NS > CHZ_NS) ? OHZ_NS : CHZ_NS;
  localparam int FLOAT_CYC = (FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W     = 4;         // timer width
  localparam logic [CNT_W-1:0] CNT_RST = 4'h0; // timer reset value
  // controller sequence states
  typedef enum logic [2:0] {
    ASC_IDLE, ASC_RD_WAIT, ASC_RD_DONE, ASC_WR_SETUP, ASC_WR_PULSE,
    ASC_WR_REC, ASC_FLOAT
  } asc_state_e;
endpackage : asc_pkg

// [hdl/asc_sync.sv]
/*
  two flip-flop synchroniser for the data pins read back from memory.
  assumes: inputs are asynchronous pins, output read in clk domain.
*/
`timescale 1ns/100ps
module asc_sync
  import asc_pkg::*;
#(
  parameter int W = DATA_W
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;  // first stage, read only by second stage

  // two stages before any logic sees the pins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule : asc_sync

// [bench/asc_mem_model.sv]
/* behavioural 32K x 8 static memory for the controller's pins.
   assumes: bench resolves the shared data wire from both enables. */
`timescale 1ns/100ps
module asc_mem_model
  import asc_pkg::*;
(
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              sel_n, wr_n, oe_n,
  input  wire logic [DATA_W-1:0] din,
  output logic      [DATA_W-1:0] dout,
  output logic                   drv
);
  logic [DATA_W-1:0] mem [1<<ADDR_W]; // 32K bytes
  // store only during the select and strobe overlap
  always @* if (!sel_n && !wr_n) mem[addr] = din;
  // drive only when selected, not writing, enabled
  assign drv  = !sel_n && wr_n && !oe_n;
  assign dout = mem[addr];
endmodule : asc_mem_model

// [bench/asc_ctrl_properties.sv]
/* pin sequencing checks for asc_ctrl.
   assumes: bound into asc_ctrl, single clock, async reset. */
`timescale 1ns/100ps
module asc_ctrl_properties
  import asc_pkg::*;
(
  input wire logic clk, rst_n, req_valid, req_write, req_ready, rsp_valid,
  input wire logic mem_sel_n, mem_wr_n, mem_oe_n, mem_data_oe_n,
  input wire logic [ADDR_W-1:0] mem_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire rd_go = req_valid && req_ready && !req_write; // read taken
  wire wr_go = req_valid && req_ready && req_write;  // write taken
  sequence rd_on; !mem_sel_n && !mem_oe_n && mem_wr_n; endsequence
  sequence wr_on;
    !mem_sel_n && !mem_wr_n && !mem_data_oe_n && mem_oe_n;
  endsequence
  rd_walk_a: assert property (
    rd_go |=> rd_on [*4] ##1 mem_sel_n && mem_oe_n) else $error("read");
  rd_resp_a: assert property (
    rd_go |-> ##6 rsp_valid) else $error("read answer late");
  wr_walk_a: assert property (
    wr_go |=> mem_sel_n ##1 wr_on ##1 mem_sel_n && mem_wr_n && !mem_data_oe_n
    ##1 mem_data_oe_n)
    else $error("write strobes");
  wr_ready_a: assert property (
    wr_go |=> !req_ready [*3] ##1 req_ready) else $error("write recovery");
  wr_oe_high_a: assert property (
    !mem_wr_n |-> mem_oe_n && !mem_sel_n) else $error("write with oe low");
  addr_move_a: assert property (
    $changed(mem_addr) |-> mem_wr_n && $past(mem_wr_n)) else $error("addr");
  bus_free_a: assert property (
    !mem_data_oe_n |-> mem_oe_n && $past(mem_oe_n)) else $error("bus clash");
  rsp_once_a: assert property (
    rsp_valid |=> !rsp_valid) else $error("answer too long");
endmodule : asc_ctrl_properties
bind asc_ctrl asc_ctrl_properties chk (.*);

// [bench/testbench.sv]
/* table of writes and reads through the memory model, then a reset
   after an untaken write. assumes: memory model and bound checker present. */
`timescale 1ns/100ps
module testbench;
  import asc_pkg::*;
  logic clk = 0, rst_n = 0, req_valid = 0, req_write = 0;
  logic [ADDR_W-1:0] req_addr = '0, mem_addr;
  logic [DATA_W-1:0] req_wdata = '0, bus, last = '0, mdat;
  logic [DATA_W-1:0] mem_data_o, rsp_rdata;
  logic req_ready, rsp_valid, mem_sel_n, mem_wr_n, mem_oe_n;
  logic mem_data_oe_n, mdrv;
  int errors = 0, checks_done = 0, cyc = 0;
  // rows: write flag, address, byte stored or expected
  logic [23:0] rows [8] = '{24'h8000a5, 24'hffff3c, 24'h800100,
    24'h0000a5, 24'h7fff3c, 24'h000100, 24'h8001ff, 24'h0001ff};
  always #50 clk = ~clk;
  // released wire shows the inverse of its last value
  assign #1 bus = !mem_data_oe_n ? mem_data_o : mdrv ? mdat : ~last;
  always @(posedge clk) last <= bus;
  asc_ctrl uut (.*, .mem_data_i(bus));
  asc_mem_model mem (.addr(mem_addr), .sel_n(mem_sel_n), .wr_n(mem_wr_n),
    .oe_n(mem_oe_n), .din(bus), .dout(mdat), .drv(mdrv));
  task chk(input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  // offer at a falling edge, count cycles until the read answer, or for a write until ready returns
  task send(input logic [23:0] r, output int n);
    n = 1;
    while (req_ready !== 1'b1) @(negedge clk);
    {req_write, req_addr, req_wdata} = r;
    req_valid = 1;
    @(negedge clk);
    req_valid = 0;
    do begin
      @(negedge clk);
      n++;
    end while (n < 20 && (r[23] ? req_ready : rsp_valid) !== 1'b1);
  endtask : send
  // bound on the whole run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      errors++;
      test_done;
    end
  end
  initial begin
    int n;
    repeat (10) @(negedge clk);
    rst_n = 1;
    foreach (rows[i]) begin
      send(rows[i], n);
      chk(8'(n), rows[i][23] ? 8'h04 : 8'h06);
      if (!rows[i][23]) chk(rsp_rdata, rows[i][7:0]);
      $display("row %0d done", i);
    end
    // write offered in the read's float wait, withdrawn untaken, then reset in idle
    {req_valid, req_write, req_addr, req_wdata} = {2'b11, 15'h0002, 8'h55};
    repeat (2) @(negedge clk);
    req_valid = 0;
    rst_n = 0;
    #1 chk({mdrv, req_ready, mem_sel_n, mem_wr_n, mem_oe_n, mem_data_oe_n},
      8'h0f);
    @(negedge clk);
    rst_n = 1;
    send(24'h7fff3c, n);
    chk(rsp_rdata, 8'h3c);
    $display("reset test done");
    test_done;
  end
endmodule : testbench
